// ===== logic/serial_eeprom_command_interface.sv
`timescale 1ns/100ps
module serial_eeprom_command_interface #(
  parameter int PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLE_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_serial_clk_in,
  input  wire logic i_chip_select,
  input  wire logic i_serial_in,
  input  wire logic i_org,
  output logic      o_serial_out,
  output logic      o_serial_out_en,
  output logic      o_busy
);

  localparam int KW = eeprom_pkg::KIND_W;
  localparam int AW = eeprom_pkg::UNIT_AW;
  localparam int DW = eeprom_pkg::WORD_W;
  localparam int BW = eeprom_pkg::BLOCK_W;

  // Link side state
  logic                 rst_link_s1;
  logic                 rst_link;
  logic                 org_l;
  logic                 rd_ack_l;
  logic                 started;
  logic [4:0]           cnt;
  logic [1:0]           op;
  logic [10:0]          addr_sr;
  logic [15:0]          data_sr;
  logic                 cmd_sent;
  logic                 ovr_sent;
  logic                 rd_mode;
  logic                 dout;
  logic                 dout_en;
  logic [1:0]           ofs;
  logic [15:0]          ush;
  logic [4:0]           bl;
  logic                 need_new;
  logic                 cmd_tgl;
  logic                 ovr_tgl;
  logic                 start_tgl;
  logic                 rdreq_tgl;
  logic [eeprom_pkg::CMD_W-1:0] cmd_l;
  logic [AW-1:0]        rdreq_base;
  logic [BW-1:0]        blk_cur;

  // Core side state
  logic                 org_c;
  logic                 cs_c;
  logic                 cmd_c;
  logic                 ovr_c;
  logic                 start_c;
  logic                 req_c;
  logic                 cs_d;
  logic                 cs_d2;
  logic                 cmd_d;
  logic                 ovr_d;
  logic                 start_d;
  logic                 req_d;
  logic                 has_cmd;
  logic                 go;
  logic [eeprom_pkg::CMD_W-1:0] pend;
  logic                 buf_ready;
  logic                 buf_valid;
  logic [eeprom_pkg::CMD_W-1:0] buf_data;
  eeprom_pkg::exec_state_e state;
  eeprom_pkg::cmd_kind_e   ex_kind;
  logic [DW-1:0]        ex_data;
  logic [8:0]           sweep_idx;
  logic [eeprom_pkg::TIMER_W-1:0] timer;
  logic                 prog_en;
  logic                 stat_arm;
  logic                 stat_on;
  logic                 stat_level;
  logic [BW-1:0]        reply;
  logic                 rd_ack;
  logic [DW-1:0]        mem [eeprom_pkg::WORDS];

  function automatic eeprom_pkg::cmd_kind_e kind_of(input logic [1:0] opc, input logic [1:0] sub);
    eeprom_pkg::cmd_kind_e k;
    k = eeprom_pkg::ERASE_CMD;
    if (opc == eeprom_pkg::OP_WRITE)
      k = eeprom_pkg::WRITE_CMD;
    else if (opc == eeprom_pkg::OP_EXT && sub == eeprom_pkg::EXT_ENABLE)
      k = eeprom_pkg::PROGRAM_ENABLE_CMD;
    else if (opc == eeprom_pkg::OP_EXT && sub == eeprom_pkg::EXT_DISABLE)
      k = eeprom_pkg::PROGRAM_DISABLE_CMD;
    else if (opc == eeprom_pkg::OP_EXT && sub == eeprom_pkg::EXT_CLEAR_ALL)
      k = eeprom_pkg::CLEAR_ALL_CMD;
    else if (opc == eeprom_pkg::OP_EXT)
      k = eeprom_pkg::FILL_ALL_CMD;
    return k;
  endfunction

  // Even byte units sit in the low half of a word
  function automatic logic [8:0] word_of(input logic [AW-1:0] u, input logic x8);
    return x8 ? u[9:1] : u[8:0];
  endfunction

  function automatic logic [DW-1:0] read_unit(input logic [AW-1:0] u, input logic x8);
    logic [DW-1:0] w;
    w = mem[word_of(u, x8)];
    return x8 ? {8'h00, (u[0] ? w[15:8] : w[7:0])} : w;
  endfunction

  function automatic logic [DW-1:0] merge_unit(input logic [DW-1:0] cur, input logic [AW-1:0] u,
                                               input logic [DW-1:0] val, input logic x8);
    logic [DW-1:0] r;
    r = val;
    if (x8)
      r = u[0] ? {val[7:0], cur[7:0]} : {cur[15:8], val[7:0]};
    return r;
  endfunction

  // Link clock domain; the frame logic is cleared while select is low
  always_ff @(posedge i_serial_clk_in or posedge i_rst)
  begin
    if (i_rst)
    begin
      rst_link_s1 <= 1'b1;
      rst_link    <= 1'b1;
    end
    else
    begin
      rst_link_s1 <= 1'b0;
      rst_link    <= rst_link_s1;
    end
  end

  level_sync #(.W(2)) u_link_sync (
    .i_clk (i_serial_clk_in),
    .i_rst (rst_link),
    .i_d   ({i_org, rd_ack}),
    .o_q   ({org_l, rd_ack_l})
  );

  wire frame_clr = rst_link | ~i_chip_select;
  wire x8_l      = ~org_l;
  wire [4:0] hdr_len = x8_l ? eeprom_pkg::FRAME_BITS_X8 - 5'h01
                            : eeprom_pkg::FRAME_BITS_X16 - 5'h01;
  wire [4:0] dw_l    = x8_l ? eeprom_pkg::DATA_BITS_X8 : eeprom_pkg::DATA_BITS_X16;
  wire [4:0] cnt_n   = (cnt == 5'h1F) ? cnt : cnt + 5'h01;
  wire [1:0] op_n    = (cnt_n <= eeprom_pkg::OPCODE_BITS) ? {op[0], i_serial_in} : op;
  wire       in_addr = (cnt_n > eeprom_pkg::OPCODE_BITS) && (cnt_n <= hdr_len);
  wire [10:0] addr_n = in_addr ? {addr_sr[9:0], i_serial_in} : addr_sr;
  wire [15:0] data_n = (cnt_n > hdr_len) ? {data_sr[14:0], i_serial_in} : data_sr;
  wire [1:0] sub_n   = x8_l ? addr_n[10:9] : addr_n[9:8];
  wire with_data     = (op_n == eeprom_pkg::OP_WRITE) ||
                       (op_n == eeprom_pkg::OP_EXT && sub_n == eeprom_pkg::EXT_FILL_ALL);
  wire [4:0] final_len = hdr_len + (with_data ? dw_l : 5'h00);
  // The top address bit is dropped here
  wire [AW-1:0] unit_n = x8_l ? addr_n[9:0] : {1'b0, addr_n[8:0]};
  wire [DW-1:0] cdata_n = x8_l ? {8'h00, data_n[7:0]} : data_n;
  wire [AW-1:0] base_n  = x8_l ? {addr_n[7:0], 2'b00} : {1'b0, addr_n[6:0], 2'b00};

  wire start_edge = i_chip_select & ~started & i_serial_in;
  wire is_read    = (op_n == eeprom_pkg::OP_READ);
  wire done_edge  = started & ~cmd_sent & ~is_read & (cnt_n == final_len);
  wire over_edge  = started & cmd_sent & ~ovr_sent;
  // The block is fetched two bits early so it has crossed by the first data bit
  wire pref_edge  = started & is_read & (cnt != cnt_n) & (cnt_n == hdr_len - 5'h02);
  wire rd_start   = started & is_read & ~rd_mode & (cnt_n == hdr_len);
  wire load_edge  = started & rd_mode & (bl == 5'h00);
  wire blk_ok     = (rd_ack_l == rdreq_tgl);
  wire [BW-1:0] src_block = need_new ? (blk_ok ? reply : '1) : blk_cur;
  wire [DW-1:0] unit_q    = src_block[ofs*DW +: DW];
  wire unit_msb           = x8_l ? unit_q[7] : unit_q[15];
  wire [15:0] unit_rest   = x8_l ? {unit_q[6:0], 9'h000} : {unit_q[14:0], 1'b0};

  always_ff @(posedge i_serial_clk_in or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      started  <= 1'b0;
      cnt      <= 5'h00;
      op       <= 2'h0;
      addr_sr  <= 11'h000;
      data_sr  <= 16'h0000;
      cmd_sent <= 1'b0;
      ovr_sent <= 1'b0;
      rd_mode  <= 1'b0;
      dout     <= 1'b0;
      dout_en  <= 1'b0;
      ofs      <= 2'h0;
      ush      <= 16'h0000;
      bl       <= 5'h00;
      need_new <= 1'b0;
    end
    else if (!started)
      started <= i_serial_in;
    else
    begin
      cnt     <= cnt_n;
      op      <= op_n;
      addr_sr <= addr_n;
      data_sr <= data_n;
      if (done_edge)
        cmd_sent <= 1'b1;
      if (over_edge)
        ovr_sent <= 1'b1;
      if (rd_start)
      begin
        rd_mode  <= 1'b1;
        dout_en  <= 1'b1;
        dout     <= 1'b0;
        ofs      <= addr_n[1:0];
        need_new <= 1'b1;
      end
      else if (load_edge)
      begin
        dout     <= unit_msb;
        ush      <= unit_rest;
        bl       <= dw_l - 5'h01;
        ofs      <= ofs + 2'h1;
        need_new <= (ofs == 2'h3);
      end
      else if (rd_mode)
      begin
        dout <= ush[15];
        ush  <= {ush[14:0], 1'b0};
        bl   <= bl - 5'h01;
      end
    end
  end

  // Words cross by toggle handshake; payloads stay still until the next toggle
  always_ff @(posedge i_serial_clk_in or posedge rst_link)
  begin
    if (rst_link)
    begin
      cmd_tgl    <= 1'b0;
      ovr_tgl    <= 1'b0;
      start_tgl  <= 1'b0;
      rdreq_tgl  <= 1'b0;
      cmd_l      <= '0;
      rdreq_base <= '0;
      blk_cur    <= '0;
    end
    else
    begin
      if (start_edge)
        start_tgl <= ~start_tgl;
      if (done_edge)
      begin
        cmd_tgl <= ~cmd_tgl;
        cmd_l   <= {kind_of(op_n, sub_n), unit_n, cdata_n};
      end
      if (over_edge)
        ovr_tgl <= ~ovr_tgl;
      if (pref_edge)
      begin
        rdreq_tgl  <= ~rdreq_tgl;
        rdreq_base <= base_n;
      end
      else if (load_edge && need_new)
      begin
        rdreq_tgl  <= ~rdreq_tgl;
        rdreq_base <= rdreq_base + 10'h004;
        blk_cur    <= src_block;
      end
    end
  end

  // Core clock domain
  level_sync #(.W(6)) u_core_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_org, i_chip_select, cmd_tgl, ovr_tgl, start_tgl, rdreq_tgl}),
    .o_q   ({org_c, cs_c, cmd_c, ovr_c, start_c, req_c})
  );

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      {cs_d, cs_d2, cmd_d, ovr_d, start_d, req_d} <= 6'h00;
    else
      {cs_d, cs_d2, cmd_d, ovr_d, start_d, req_d} <= {cs_c, cs_d, cmd_c, ovr_c, start_c, req_c};
  end

  wire x8_c     = ~org_c;
  wire cmd_ev   = cmd_c ^ cmd_d;
  wire ovr_ev   = ovr_c ^ ovr_d;
  wire start_ev = start_c ^ start_d;
  wire req_ev   = req_c ^ req_d;
  // Select fall is acted on one cycle late so a late overrun toggle always lands first
  wire cs_fall  = cs_d2 & ~cs_d;
  wire cs_rise  = cs_c & ~cs_d;
  wire push     = go & buf_ready;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      has_cmd <= 1'b0;
      go      <= 1'b0;
      pend    <= '0;
    end
    else if (cmd_ev)
    begin
      has_cmd <= 1'b1;
      go      <= 1'b0;
      pend    <= cmd_l;
    end
    else if (push || (ovr_ev && !go))
    begin
      has_cmd <= 1'b0;
      go      <= 1'b0;
    end
    else if (cs_fall && has_cmd)
      go <= 1'b1;
  end

  // Commands queue here while a cycle runs; a full queue holds the pending one back
  two_entry_buffer #(.W(eeprom_pkg::CMD_W), .DEPTH(2)) u_cmd_buffer (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (go),
    .o_ready (buf_ready),
    .i_data  (pend),
    .o_valid (buf_valid),
    .i_ready (state == eeprom_pkg::ST_IDLE),
    .o_data  (buf_data)
  );

  wire eeprom_pkg::cmd_kind_e q_kind = eeprom_pkg::cmd_kind_e'(buf_data[eeprom_pkg::CMD_W-1 -: KW]);
  wire [AW-1:0] q_addr = buf_data[DW +: AW];
  wire [DW-1:0] q_data = buf_data[DW-1:0];
  wire q_all  = (q_kind == eeprom_pkg::CLEAR_ALL_CMD) || (q_kind == eeprom_pkg::FILL_ALL_CMD);
  wire q_prog = q_all || (q_kind == eeprom_pkg::ERASE_CMD) || (q_kind == eeprom_pkg::WRITE_CMD);
  wire pop    = (state == eeprom_pkg::ST_IDLE) & buf_valid;
  wire accept = pop & q_prog & prog_en;

  wire [8:0]    one_idx   = word_of(q_addr, x8_c);
  wire [DW-1:0] one_val   = (q_kind == eeprom_pkg::ERASE_CMD) ? eeprom_pkg::ERASED_WORD : q_data;
  wire [DW-1:0] one_wdata = merge_unit(mem[one_idx], q_addr, one_val, x8_c);
  wire [DW-1:0] all_wdata = (ex_kind == eeprom_pkg::CLEAR_ALL_CMD) ? eeprom_pkg::ERASED_WORD
                          : (x8_c ? {ex_data[7:0], ex_data[7:0]} : ex_data);
  wire sweeping = (state == eeprom_pkg::ST_SWEEP);
  wire mem_we   = (accept & ~q_all) | sweeping;
  wire [8:0]    mem_idx   = sweeping ? sweep_idx : one_idx;
  wire [DW-1:0] mem_wdata = sweeping ? all_wdata : one_wdata;

  always_ff @(posedge i_clk)
  begin
    if (mem_we)
      mem[mem_idx] <= mem_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      prog_en <= 1'b0;
    else if (pop && q_kind == eeprom_pkg::PROGRAM_ENABLE_CMD)
      prog_en <= 1'b1;
    else if (pop && q_kind == eeprom_pkg::PROGRAM_DISABLE_CMD)
      prog_en <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state     <= eeprom_pkg::ST_IDLE;
      ex_kind   <= eeprom_pkg::ERASE_CMD;
      ex_data   <= '0;
      sweep_idx <= 9'h000;
      timer     <= '0;
    end
    else
    begin
      if (timer != '0)
        timer <= timer - 1'b1;
      case (state)
        eeprom_pkg::ST_IDLE:
          if (accept)
          begin
            ex_kind   <= q_kind;
            ex_data   <= q_data;
            sweep_idx <= 9'h000;
            timer     <= eeprom_pkg::TIMER_W'(PROGRAM_CYCLES - 1);
            state     <= q_all ? eeprom_pkg::ST_SWEEP : eeprom_pkg::ST_WAIT;
          end
        eeprom_pkg::ST_SWEEP:
        begin
          sweep_idx <= sweep_idx + 9'h001;
          if (sweep_idx == 9'(eeprom_pkg::WORDS - 1))
            state <= eeprom_pkg::ST_WAIT;
        end
        eeprom_pkg::ST_WAIT:
          if (timer == '0)
            state <= eeprom_pkg::ST_IDLE;
        default:
          state <= eeprom_pkg::ST_IDLE;
      endcase
    end
  end

  wire next_busy = (state != eeprom_pkg::ST_IDLE) | buf_valid | go;

  // Status stays on until a one is shifted in or select drops
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_busy     <= 1'b0;
      stat_arm   <= 1'b0;
      stat_on    <= 1'b0;
      stat_level <= 1'b0;
    end
    else
    begin
      o_busy     <= next_busy;
      stat_level <= ~next_busy;
      stat_arm   <= accept | (stat_arm & ~start_ev);
      stat_on    <= cs_c & ~start_ev & (stat_on | (cs_rise & (stat_arm | accept)));
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      reply  <= '0;
      rd_ack <= 1'b0;
    end
    else if (req_ev)
    begin
      for (int i = 0; i < eeprom_pkg::BLOCK_UNITS; i++)
        reply[i*DW +: DW] <= read_unit(rdreq_base + AW'(i), x8_c);
      rd_ack <= req_c;
    end
  end

  assign o_serial_out    = dout_en ? dout : stat_level;
  assign o_serial_out_en = dout_en | stat_on;

endmodule // serial_eeprom_command_interface

// ===== logic/eeprom_pkg.sv
package eeprom_pkg;

  // Core clock and the self-timed program cycle
  localparam int CLK_MHZ               = 50;
  localparam int PROGRAM_CYCLE_TIME_US = 5000;
  // Longest time: rounds down; 5000 us at 50 MHz is exact
  localparam int PROGRAM_CYCLE_CYCLES  = (PROGRAM_CYCLE_TIME_US * CLK_MHZ * 1000) / 1000;
  localparam int TIMER_W               = 18;

  // Frame lengths, start bit included, write data excluded
  localparam logic [4:0] FRAME_BITS_X8  = 5'h0E;
  localparam logic [4:0] FRAME_BITS_X16 = 5'h0D;
  localparam logic [4:0] DATA_BITS_X8   = 5'h08;
  localparam logic [4:0] DATA_BITS_X16  = 5'h10;
  localparam logic [4:0] OPCODE_BITS    = 5'h02;

  // Storage: 512 words of 16 bits; a unit is a byte (x8) or a word (x16)
  localparam int WORD_W      = 16;
  localparam int WORDS       = 512;
  localparam int UNIT_AW     = 10;
  localparam int BLOCK_UNITS = 4;
  localparam int BLOCK_W     = BLOCK_UNITS * WORD_W;
  localparam int KIND_W      = 3;
  localparam int CMD_W       = KIND_W + UNIT_AW + WORD_W;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;

  // Top two address bits of an OP_EXT frame
  localparam logic [1:0] EXT_DISABLE   = 2'h0;
  localparam logic [1:0] EXT_FILL_ALL  = 2'h1;
  localparam logic [1:0] EXT_CLEAR_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE    = 2'h3;

  typedef enum logic [2:0] {
    ERASE_CMD           = 3'h0,
    WRITE_CMD           = 3'h1,
    CLEAR_ALL_CMD       = 3'h2,
    FILL_ALL_CMD        = 3'h3,
    PROGRAM_ENABLE_CMD  = 3'h4,
    PROGRAM_DISABLE_CMD = 3'h5
  } cmd_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SWEEP = 3'b010,
    ST_WAIT  = 3'b100
  } exec_state_e;

endpackage

// ===== logic/level_sync.sv
`timescale 1ns/100ps
module level_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] stage;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      stage <= '0;
      o_q   <= '0;
    end
    else
    begin
      stage <= i_d;
      o_q   <= stage;
    end
  end

endmodule // level_sync

// ===== logic/two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int W     = eeprom_pkg::CMD_W,
  parameter int DEPTH = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic      [W-1:0] o_data
);

  logic [W-1:0] slot [DEPTH];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;

  wire push = i_valid & o_ready;
  wire pop  = o_valid & i_ready;

  assign o_ready = (count != 2'(DEPTH));
  assign o_valid = (count != 2'h0);
  assign o_data  = slot[rd_ptr];

  always_ff @(posedge i_clk)
  begin
    if (push)
      slot[wr_ptr] <= i_data;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count  <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // two_entry_buffer

// ===== testbench/eeprom_link_checker.sv
`timescale 1ns/100ps
module eeprom_link_checker #(
  parameter int PROGRAM_CYCLES = 50
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_serial_clk_in,
  input wire logic i_chip_select,
  input wire logic i_serial_in,
  input wire logic i_org,
  input wire logic o_serial_out,
  input wire logic o_serial_out_en,
  input wire logic o_busy
);
  // Room for the running cycle plus every queued one
  localparam int BUSY_LIMIT = 4 * PROGRAM_CYCLES + 2200;
  int run_len;
  always_ff @(posedge i_clk)
  begin
    run_len <= (i_rst || !o_busy) ? 0 : run_len + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence link_still;
    !i_serial_clk_in[*3];
  endsequence
  sequence busy_poll;
    $rose(i_chip_select) ##1 (i_chip_select && !i_serial_clk_in && o_busy)[*6];
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) i_rst ##1 i_rst |-> !o_busy && !o_serial_out_en)
    else $error("outputs active during reset");
  deselect_hiz_a: assert property (!i_chip_select[*5] |-> !o_serial_out_en)
    else $error("output driven while deselected");
  select_drive_a: assert property ($rose(o_serial_out_en) |-> i_chip_select)
    else $error("output enabled without select");
  busy_status_a: assert property (busy_poll |-> o_serial_out_en && !o_serial_out)
    else $error("busy status not shown low");
  cycle_long_a: assert property ($fell(o_busy) && run_len > 32 |-> run_len >= PROGRAM_CYCLES)
    else $error("program cycle ended early");
  cycle_bound_a: assert property (o_busy |-> run_len < BUSY_LIMIT)
    else $error("program cycle never ends");
  start_on_deselect_a: assert property (i_chip_select[*8] |=> !$rose(o_busy))
    else $error("cycle started while selected");
  hold_bits_a: assert property (link_still ##0 (i_chip_select && o_serial_out_en && $past(o_serial_out_en)
    && !o_busy && !$past(o_busy, 4)) |-> $stable(o_serial_out))
    else $error("output changed without link edge");
endmodule // eeprom_link_checker

bind serial_eeprom_command_interface eeprom_link_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_serial_clk_in(i_serial_clk_in), .i_chip_select(i_chip_select),
  .i_serial_in(i_serial_in), .i_org(i_org), .o_serial_out(o_serial_out),
  .o_serial_out_en(o_serial_out_en), .o_busy(o_busy));

// ===== testbench/eeprom_host.sv
`timescale 1ns/100ps
module eeprom_host (
  input  wire logic i_do,
  output logic      o_sk,
  output logic      o_cs,
  output logic      o_di
);
  initial
  begin
    o_sk = 1'b0;
    o_di = 1'b0;
    // Select settles after reset rises, so the frame clear sees a real edge
    #2 o_cs = 1'b0;
  end
  // Link clock only runs inside pulses, 160 ns each
  task automatic pulse(input logic b, output logic q);
    o_di = b;
    #80 o_sk = 1'b1;
    #76 q = i_do;
    #4 o_sk = 1'b0;
  endtask
  task automatic idle_clocks();
    logic q;
    repeat (2) pulse(1'b0, q);
  endtask
  task automatic send(input logic [1:0] op, input logic [10:0] ad, input logic [16:0] dt, input int nd,
                      input logic x8, output logic [63:0] q);
    int n;
    logic [63:0] v;
    logic b;
    n = x8 ? 14 : 13;
    v = (64'({1'b1, op}) << (n - 3)) | (64'(ad) & ((64'h1 << (n - 3)) - 1));
    v = (v << nd) | 64'(dt);
    q = '0;
    o_cs = 1'b1;
    for (int k = n + nd - 1; k >= 0; k--)
    begin
      pulse(v[k], b);
      q = {q[62:0], b};
    end
    // Released line shows the inverse so a stale value cannot pass
    o_di = ~o_di;
    #20 o_cs = 1'b0;
    #200;
  endtask
  task automatic poll();
    o_cs = 1'b1;
    #300 o_cs = 1'b0;
    #200;
  endtask
endmodule // eeprom_host

// ===== testbench/serial_eeprom_command_interface_bench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module serial_eeprom_command_interface_bench;
  logic        i_clk, i_rst, i_org, x8;
  wire logic   sk, cs, di, o_serial_out, o_serial_out_en, o_busy;
  int          n_fail, cmp_count, seed;
  logic [15:0] mem [512];
  logic [63:0] got;
  logic [15:0] d;
  logic [10:0] a;
  serial_eeprom_command_interface #(.PROGRAM_CYCLES(600)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_serial_clk_in(sk), .i_chip_select(cs), .i_serial_in(di), .i_org(i_org), .o_serial_out(o_serial_out),
    .o_serial_out_en(o_serial_out_en), .o_busy(o_busy));
  eeprom_host u_host (.i_do(o_serial_out), .o_sk(sk), .o_cs(cs), .o_di(di));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  function automatic logic [10:0] ext(input logic [1:0] c);
    return x8 ? {c, 9'h155} : {1'b0, c, 8'hA5};
  endfunction
  function automatic logic [32:0] seq16(input logic [8:0] w);
    return {1'b0, mem[w], mem[w + 9'h1]};
  endfunction
  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic status(input logic [1:0] e);
    fork
      u_host.poll();
      #200 `CHK("status", e, {o_serial_out_en, o_serial_out})
    join
  endtask
  task automatic prog(input logic [1:0] op, input logic [10:0] ad, input logic [16:0] dt, input int nd, input logic ok);
    u_host.send(op, ad, dt, nd, x8, got);
    repeat (10) @(negedge i_clk);
    `CHK("busy", ok, o_busy)
    if (ok)
    begin
      status(2'b10);
      for (int k = 0; k < 2000 && o_busy; k++) @(negedge i_clk);
      `CHK("ready", 1'b0, o_busy)
      status(2'b11);
    end
  endtask
  task automatic rd16(input logic [10:0] ad);
    u_host.send(eeprom_pkg::OP_READ, ad, 17'h0, 32, x8, got);
    `CHK("read", seq16(ad[8:0]), got[32:0])
  endtask
  initial
  begin
    seed = 40;
    // A clean rising reset edge, so the link side is cleared for sure
    i_rst = 1'b0;
    #1 i_rst = 1'b1;
    i_org = 1'b1;
    x8 = 1'b0;
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    u_host.idle_clocks();
    prog(eeprom_pkg::OP_WRITE, 11'h005, 17'h1234, 16, 1'b0);
    u_host.send(eeprom_pkg::OP_EXT, ext(eeprom_pkg::EXT_ENABLE), 17'h0, 0, x8, got);
    prog(eeprom_pkg::OP_EXT, ext(eeprom_pkg::EXT_CLEAR_ALL), 17'h0, 0, 1'b1);
    foreach (mem[i]) mem[i] = 16'hFFFF;
    rd16(11'($random(seed)));
    d = 16'($random(seed));
    prog(eeprom_pkg::OP_EXT, ext(eeprom_pkg::EXT_FILL_ALL), {1'b0, d}, 16, 1'b1);
    foreach (mem[i]) mem[i] = d;
    rd16(11'($random(seed)));
    for (int i = 0; i < 4; i++)
    begin
      // First pass sits on the last word so the sequential read wraps
      a = (i == 0) ? {1'($random(seed)), 10'h1FF} : 11'($random(seed));
      d = 16'($random(seed));
      prog(eeprom_pkg::OP_WRITE, a, {1'b0, d}, 16, 1'b1);
      mem[a[8:0]] = d;
      rd16(a);
    end
    prog(eeprom_pkg::OP_ERASE, a, 17'h0, 0, 1'b1);
    mem[a[8:0]] = 16'hFFFF;
    rd16(a);
    prog(eeprom_pkg::OP_WRITE, a, {16'h0F0F, 1'b1}, 17, 1'b0);
    rd16(a);
    @(negedge i_clk);
    i_org = 1'b0;
    x8 = 1'b1;
    d = 16'($random(seed));
    prog(eeprom_pkg::OP_WRITE, a, {9'h0, d[7:0]}, 8, 1'b1);
    u_host.send(eeprom_pkg::OP_READ, a, 17'h0, 8, x8, got);
    `CHK("byte read", {1'b0, d[7:0]}, got[8:0])
    u_host.send(eeprom_pkg::OP_EXT, ext(eeprom_pkg::EXT_DISABLE), 17'h0, 0, x8, got);
    prog(eeprom_pkg::OP_WRITE, a, {9'h0, ~d[7:0]}, 8, 1'b0);
    u_host.send(eeprom_pkg::OP_READ, a, 17'h0, 8, x8, got);
    `CHK("byte kept", {1'b0, d[7:0]}, got[8:0])
    give_verdict();
  end
  initial
  begin
    #1500000;
    n_fail++;
    give_verdict();
  end
endmodule // serial_eeprom_command_interface_bench
